// file: core/gpl_pkg.sv
// Constants and carrier types for the byte-wide general purpose port block.
// Assumes one system clock and a simple strobe register port.
package gpl_pkg;
  // ==========================================================================
  // Sizes
  localparam int GPL_PORT_W = 8;
  localparam int GPL_ADDR_W = 4;
  localparam int GPL_DATA_W = 8;
  localparam int GPL_HD_PINS = 8;

  // ==========================================================================
  // Register map
  localparam logic [GPL_ADDR_W-1:0] GPL_DATA_BASE = 4'h0;
  localparam logic [GPL_ADDR_W-1:0] GPL_DIR_BASE = 4'h1;
  localparam logic [GPL_ADDR_W-1:0] GPL_PORT_STEP = 4'h2;
  localparam logic [GPL_ADDR_W-1:0] GPL_PULLUP_ADDR = 4'h8;
  localparam logic [GPL_ADDR_W-1:0] GPL_DRIVE_ADDR = 4'h9;

  // ==========================================================================
  // Reset values
  localparam logic GPL_DIR_INPUT = 1'b0;
  localparam logic GPL_DIR_OUTPUT = 1'b1;
  localparam logic [GPL_DATA_W-1:0] GPL_LATCH_RST = 8'h00;
  localparam logic [GPL_DATA_W-1:0] GPL_PULLUP_RST = 8'h00;
  localparam logic [GPL_DATA_W-1:0] GPL_DRIVE_RST = 8'h00;
  localparam logic [GPL_DATA_W-1:0] GPL_READ_ZERO = 8'h00;

  // ==========================================================================
  // Register port request
  typedef struct packed {
    logic [GPL_ADDR_W-1:0] addr;
    logic [GPL_DATA_W-1:0] wdata;
    logic we;
    logic re;
  } gpl_bus_s;
endpackage

// file: core/gpl_port.sv
// General purpose I/O ports with output latch, byte direction, pull-up and high drive.
// Assumes pin inputs are synchronous to clk_i and the bus master never stalls.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// Contract
// R1 - Pull-up applies only while the port is input; ignored in output mode.
// R2 - One direction bit per port governs all eight pins together.
// R3 - Input-mode read of port register returns sampled pin level.
// R4 - Input-mode write updates the latch without driving pins.
// R5 - Output-mode write updates latch and the pins show the latch.
// R6 - Output-mode read returns latch, or peripheral output for selected ports.
// R7 - Direction registers are write-only and read back as zero.
// R8 - After reset all ports are inputs until software writes output direction.
// R9 - Exactly eight pins offer selectable high drive capability.
// R10 - Software expects read-modify-write to copy pin levels into input-mode latches.
// R11 - Software expects read-modify-write to copy peripheral output into latches.
// R12 - Software should rewrite direction settings periodically.
// R13 - Direction one is output, zero is input; pull-ups reset disabled.
module gpl_port
  import gpl_pkg::*;
#(
  parameter int NUM_PORTS = 4,
  parameter logic [NUM_PORTS-1:0] PERIPH_READ = '0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire gpl_bus_s bus_i,
  output logic [GPL_DATA_W-1:0] rdata_o,
  input wire logic [NUM_PORTS*GPL_PORT_W-1:0] pin_in_i,
  input wire logic [NUM_PORTS*GPL_PORT_W-1:0] periph_i,
  output logic [NUM_PORTS*GPL_PORT_W-1:0] pin_out_o,
  output logic [NUM_PORTS*GPL_PORT_W-1:0] pin_oe_o,
  output logic [NUM_PORTS-1:0] pin_pu_o,
  output logic [GPL_HD_PINS-1:0] pin_hd_o
);

  // ==========================================================================
  // Address decode
  function automatic logic [GPL_ADDR_W-1:0] port_addr(input int p, input logic is_dir);
    port_addr = GPL_ADDR_W'(p * GPL_PORT_STEP) + (is_dir ? GPL_DIR_BASE : GPL_DATA_BASE);
  endfunction

  // ==========================================================================
  // State
  logic [NUM_PORTS*GPL_PORT_W-1:0] latch_r, latch_nxt;
  logic [NUM_PORTS-1:0] dir_r, dir_nxt;
  logic [NUM_PORTS-1:0] pu_sel_r, pu_sel_nxt;
  logic [NUM_PORTS-1:0] pu_r, pu_nxt;
  logic [NUM_PORTS*GPL_PORT_W-1:0] oe_r, oe_nxt;
  logic [GPL_HD_PINS-1:0] hd_r, hd_nxt;
  logic [GPL_DATA_W-1:0] rdata_r, rdata_nxt;

  // ==========================================================================
  // Port latch and direction
  always_comb begin
    latch_nxt = latch_r;
    dir_nxt = dir_r;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // The latch takes every write in either mode.
      if (bus_i.we && bus_i.addr == port_addr(p, 1'b0)) begin
        latch_nxt[p*GPL_PORT_W +: GPL_PORT_W] = bus_i.wdata; // see R4 see R5
      end
      if (bus_i.we && bus_i.addr == port_addr(p, 1'b1)) begin
        dir_nxt[p] = bus_i.wdata[0]; // see R2 see R13
      end
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      oe_nxt[p*GPL_PORT_W +: GPL_PORT_W] = {GPL_PORT_W{dir_nxt[p]}}; // see R2 see R5
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latch_r <= {NUM_PORTS{GPL_LATCH_RST}};
      dir_r <= {NUM_PORTS{GPL_DIR_INPUT}}; // see R8
      oe_r <= '0;
    end else begin
      latch_r <= latch_nxt;
      dir_r <= dir_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ==========================================================================
  // Pull-up selection
  always_comb begin
    pu_sel_nxt = pu_sel_r;
    if (bus_i.we && bus_i.addr == GPL_PULLUP_ADDR) begin
      pu_sel_nxt = bus_i.wdata[NUM_PORTS-1:0];
    end
    pu_nxt = pu_sel_nxt & ~dir_nxt; // see R1
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu_sel_r <= GPL_PULLUP_RST[NUM_PORTS-1:0]; // see R13
      pu_r <= GPL_PULLUP_RST[NUM_PORTS-1:0];
    end else begin
      pu_sel_r <= pu_sel_nxt;
      pu_r <= pu_nxt;
    end
  end

  // ==========================================================================
  // High drive selection
  always_comb begin
    hd_nxt = hd_r;
    if (bus_i.we && bus_i.addr == GPL_DRIVE_ADDR) begin
      hd_nxt = bus_i.wdata[GPL_HD_PINS-1:0]; // see R9
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hd_r <= GPL_DRIVE_RST[GPL_HD_PINS-1:0];
    end else begin
      hd_r <= hd_nxt;
    end
  end

  // ==========================================================================
  // Read data
  always_comb begin
    rdata_nxt = GPL_READ_ZERO; // see R7
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (bus_i.re && bus_i.addr == port_addr(p, 1'b0)) begin
        if (dir_r[p] == GPL_DIR_INPUT) begin
          rdata_nxt = pin_in_i[p*GPL_PORT_W +: GPL_PORT_W]; // see R3
        end else if (PERIPH_READ[p]) begin
          rdata_nxt = periph_i[p*GPL_PORT_W +: GPL_PORT_W]; // see R6
        end else begin
          rdata_nxt = latch_r[p*GPL_PORT_W +: GPL_PORT_W]; // see R6
        end
      end
      // Direction reads fall through and return zero.
    end
    if (bus_i.re && bus_i.addr == GPL_PULLUP_ADDR) begin
      rdata_nxt = GPL_DATA_W'(pu_sel_r);
    end
    if (bus_i.re && bus_i.addr == GPL_DRIVE_ADDR) begin
      rdata_nxt = GPL_DATA_W'(hd_r);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= GPL_READ_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign pin_out_o = latch_r;
  assign pin_oe_o = oe_r;
  assign pin_pu_o = pu_r;
  assign pin_hd_o = hd_r;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_pullup_gated: assert property ((pin_pu_o & dir_r) == '0) // see R1
    else $error("Pull-up active on an output port.");

  chk_drive_select: assert property (bus_i.we && bus_i.addr == GPL_DRIVE_ADDR // see R9
      |=> pin_hd_o == $past(bus_i.wdata))
    else $error("High drive select not taken from write.");

  chk_drive_hold: assert property (!(bus_i.we && bus_i.addr == GPL_DRIVE_ADDR) // see R9
      |=> $stable(pin_hd_o))
    else $error("High drive select changed without a write.");

  chk_dir_readzero: assert property (bus_i.re && bus_i.addr[0] == GPL_DIR_BASE[0] // see R7
      && bus_i.addr < GPL_PULLUP_ADDR |=> rdata_o == GPL_READ_ZERO)
    else $error("Direction register read back non-zero.");

  for (genvar g = 0; g < NUM_PORTS; g++) begin : g_chk
    chk_byte_dir: assert property (pin_oe_o[g*GPL_PORT_W +: GPL_PORT_W] == '0 // see R2
        || pin_oe_o[g*GPL_PORT_W +: GPL_PORT_W] == '1)
      else $error("Port pins disagree on direction.");

    chk_input_read: assert property (bus_i.re && bus_i.addr == port_addr(g, 1'b0) // see R3
        && !dir_r[g] |=> rdata_o == $past(pin_in_i[g*GPL_PORT_W +: GPL_PORT_W]))
      else $error("Input read did not return pin level.");

    chk_input_write: assert property (bus_i.we && bus_i.addr == port_addr(g, 1'b0) // see R4
        && !dir_r[g] && !dir_nxt[g] |=> pin_out_o[g*GPL_PORT_W +: GPL_PORT_W]
        == $past(bus_i.wdata) && pin_oe_o[g*GPL_PORT_W] == 1'b0)
      else $error("Input write drove pins or missed latch.");

    chk_latch_hold: assert property (!(bus_i.we && bus_i.addr == port_addr(g, 1'b0)) // see R4
        |=> $stable(pin_out_o[g*GPL_PORT_W +: GPL_PORT_W]))
      else $error("Port latch changed without a write.");

    chk_output_write: assert property (bus_i.we && bus_i.addr == port_addr(g, 1'b0) // see R5
        && dir_r[g] |=> pin_out_o[g*GPL_PORT_W +: GPL_PORT_W] == $past(bus_i.wdata)
        && pin_oe_o[g*GPL_PORT_W +: GPL_PORT_W] == '1)
      else $error("Output write not driven to pins.");

    chk_output_drive: assert property (dir_r[g] |-> pin_oe_o[g*GPL_PORT_W +: GPL_PORT_W] == '1) // see R5
      else $error("Output port pins not driven.");

    chk_output_read: assert property (bus_i.re && bus_i.addr == port_addr(g, 1'b0) // see R6
        && dir_r[g] |=> rdata_o == (PERIPH_READ[g]
        ? $past(periph_i[g*GPL_PORT_W +: GPL_PORT_W])
        : $past(latch_r[g*GPL_PORT_W +: GPL_PORT_W])))
      else $error("Output read returned wrong source.");

    chk_output_cause: assert property ($rose(pin_oe_o[g*GPL_PORT_W]) // see R8 see R13
        |-> $past(bus_i.we && bus_i.addr == port_addr(g, 1'b1)
        && bus_i.wdata[0] == GPL_DIR_OUTPUT))
      else $error("Port became output without a direction write.");

    chk_dir_hold: assert property (!(bus_i.we && bus_i.addr == port_addr(g, 1'b1)) // see R8
        |=> $stable(pin_oe_o[g*GPL_PORT_W +: GPL_PORT_W]))
      else $error("Port direction changed without a write.");

    chk_pullup_input: assert property (!dir_r[g] |-> pin_pu_o[g] == pu_sel_r[g]) // see R1
      else $error("Input port pull-up does not follow its selection.");
  end

endmodule

// file: bench/gpl_board.sv
// Board model for the port pins: external drivers, pull-ups and floating lines.
// Assumes four byte ports and one system clock shared with the port block.
`timescale 1ns/1ps
module gpl_board (
  input wire logic clk_i,
  input wire logic [31:0] out_i,
  input wire logic [31:0] oe_i,
  input wire logic [3:0] pu_i,
  input wire logic [31:0] ext_i,
  input wire logic [31:0] ext_en_i,
  output logic [31:0] pin_o
);
  // ==========================================================================
  // Pin level
  logic [31:0] last_r = '0;
  always_ff @(posedge clk_i) begin
    last_r <= pin_o;
  end
  // A floating line with no pull-up wanders, so it shows the inverse of its last level.
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (oe_i[i]) begin
        pin_o[i] = out_i[i];
      end else if (ext_en_i[i]) begin
        pin_o[i] = ext_i[i];
      end else if (pu_i[i/8]) begin
        pin_o[i] = 1'b1;
      end else begin
        pin_o[i] = ~last_r[i];
      end
    end
  end
endmodule

// file: bench/gpl_port_latch_direction_tb.sv
// Self-checking bench for the byte port block with a board model on its pins.
// Assumes the design package and the port block are compiled first.
`timescale 1ns/1ps
module gpl_port_latch_direction_tb;
  import gpl_pkg::*;
  typedef struct packed {logic we; logic [3:0] a; logic [7:0] d;} gpl_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  gpl_bus_s bus = '0;
  logic [7:0] rdata_o, pin_hd_o;
  logic [31:0] pin_in, pin_out_o, pin_oe_o;
  logic [3:0] pin_pu_o;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  gpl_row_s rows [13] = '{
    '{1'b1, 4'h0, 8'h5A}, '{1'b0, 4'h0, 8'hC3},
    '{1'b0, 4'h1, 8'h00}, '{1'b1, 4'h1, 8'h01},
    '{1'b0, 4'h0, 8'h5A}, '{1'b1, 4'h8, 8'h0F},
    '{1'b0, 4'h2, 8'hFF}, '{1'b0, 4'h8, 8'h0F},
    '{1'b1, 4'h9, 8'hA5}, '{1'b0, 4'h9, 8'hA5},
    '{1'b1, 4'h3, 8'h01}, '{1'b1, 4'h2, 8'h33},
    '{1'b0, 4'h2, 8'h96}};
  always #20 clk = ~clk;
  gpl_port #(.NUM_PORTS(4), .PERIPH_READ(4'h2)) gpl_port_inst (.clk_i(clk), .rst_n_i(rst_n),
    .bus_i(bus), .rdata_o(rdata_o), .pin_in_i(pin_in), .periph_i(32'h0000_9600),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .pin_pu_o(pin_pu_o), .pin_hd_o(pin_hd_o));
  gpl_board gpl_board_inst (.clk_i(clk), .out_i(pin_out_o), .oe_i(pin_oe_o), .pu_i(pin_pu_o),
    .ext_i(32'h0000_00C3), .ext_en_i(32'h0000_00FF), .pin_o(pin_in));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic access(input gpl_row_s r);
    @(posedge clk);
    bus <= '{addr: r.a, wdata: r.d, we: r.we, re: ~r.we};
    @(posedge clk);
    bus <= '0;
    #1;
    if (!r.we) chk({24'h0, rdata_o}, {24'h0, r.d});
  endtask
  task automatic rmw(input logic [3:0] a, input logic [7:0] m);
    logic [7:0] v;
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    v = rdata_o | m;
    access('{1'b1, a, v});
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles > 2000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) access(rows[i]);
    chk(pin_oe_o, 32'h0000_FFFF);
    chk(pin_out_o, 32'h0000_335A);
    chk({20'h0, pin_pu_o, pin_hd_o}, {20'h0, 4'hC, 8'hA5});
    access('{1'b1, 4'hA, 8'h55});
    access('{1'b0, 4'hA, 8'h00});
    access('{1'b1, 4'h0, 8'h11});
    chk(pin_in[7:0], 8'h11);
    rmw(4'h2, 8'h01);
    chk(pin_out_o[15:8], 8'h97);
    access('{1'b1, 4'h1, 8'h01});
    chk(pin_oe_o[15:0], 16'hFFFF);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({pin_oe_o[7:0], pin_pu_o, pin_hd_o}, 20'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    access('{1'b0, 4'h0, 8'hC3});
    access('{1'b0, 4'h8, 8'h00});
    rmw(4'h0, 8'h08);
    chk({pin_oe_o[7:0], pin_out_o[7:0]}, 16'h00CB);
    complete_run();
  end
endmodule
